// *** hw/mac_pkg.sv ***
// Purpose: Shared constants for the monitor converter control block
// Assumes: 200 MHz core clock
// Notes: Register byte addresses, field positions, reset values and timing
package mac_pkg;
   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [7:0] MAC_ADDR_OPT_LO = 8'h3A;
   localparam logic [7:0] MAC_ADDR_OPT_HI = 8'h3B;
   localparam logic [15:0] MAC_OPT_RESET = 16'h2000;
   localparam int MAC_BIT_MODE = 15;
   localparam int MAC_BIT_START = 14;
   localparam int MAC_BIT_RANGE = 13;
   localparam int MAC_NUM_CHAN = 8;
   // Channel index = enable bit position = result slot
   localparam logic [2:0] MAC_CH_BATTERY_VOLTAGE = 3'h0;
   localparam logic [2:0] MAC_CH_COMPARATOR_INPUT = 3'h7;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int MAC_CLK_HZ = 200_000_000;
   localparam int MAC_CHAN_TIME_MS = 25;
   localparam int MAC_PERIOD_TIME_S = 1;
   localparam int MAC_CHAN_CYCLES = MAC_CLK_HZ / 1000 * MAC_CHAN_TIME_MS;
   localparam int MAC_PERIOD_CYCLES = MAC_CLK_HZ * MAC_PERIOD_TIME_S;

   // ************************************************************
   // Result scaling, mV per code step
   // ************************************************************
   localparam logic [3:0] MAC_STEP_LOW_MV = 4'h8;
   localparam logic [3:0] MAC_STEP_HIGH_MV = 4'hC;

   typedef enum logic [1:0] {
      MAC_ST_IDLE = 2'b00,
      MAC_ST_CONV = 2'b01,
      MAC_ST_WAIT = 2'b10
   } mac_state_type;
endpackage

// *** hw/mac_result_mem.sv ***
// Purpose: Eight-entry result store for converter channel codes
// Assumes: One write and one read port on the core clock
// Notes: Read data comes out of a register one cycle after the index
`timescale 1ns/10ps
`default_nettype none
module mac_result_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_idx,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [$clog2(DEPTH)-1:0] rd_idx,
   output logic [WIDTH-1:0] rd_data_r
);
   logic [WIDTH-1:0] mem_r [DEPTH];

   initial begin
      if (DEPTH < 2 || WIDTH < 1) $error("mac_result_mem: bad geometry");
   end

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_r[wr_idx] <= wr_data;
      end
   end

   // No reset on the array; reads before the first set return stale codes
   always_ff @(posedge clk) begin
      rd_data_r <= mem_r[rd_idx];
   end
endmodule
`default_nettype wire

// *** hw/mac_ctrl.sv ***
// Purpose: Monitor converter control, option register, channel sequencer
// Assumes: Register port and converter data come from logic on clk
// Notes: The analog conversion lives outside; this block times the slots
//
// Operation
// RULE1: With mode bit 0 one set of conversions runs on the enabled channels after start is set.
// RULE2: With mode bit 1 a full set repeats and refreshes the results once every second.
// RULE3: Start clears itself when a one-shot set ends; writing 1 starts, writing 0 requests none.
// RULE4: Each enabled channel takes one 25 ms slot, so a set lasts 25 ms times the enabled count.
// RULE5: Channels run in the order battery, system voltage, charge, discharge, input, power, bus, comparator.
// RULE6: The converter stays inactive in low power mode whatever start and enables say.
// RULE7: The host leaves low power mode before setting start or enabling channels.
// RULE8: The range bit picks 2.04 V (0) or 3.06 V (1) for system power and comparator input, reset 1.
// RULE9: Ranged channels scale at 8 mV per code low and 12 mV per code high.
// RULE10: The low byte holds one enable per channel, bit 7 comparator down to bit 0 battery, reset 0.
// RULE11: In continuous mode sets keep running while start is 1; writing 0 stops further sets.
`timescale 1ns/10ps
`default_nettype none
module mac_ctrl
   import mac_pkg::*;
#(
   parameter int CHAN_CYCLES = MAC_CHAN_CYCLES,
   parameter int PERIOD_CYCLES = MAC_PERIOD_CYCLES
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wr_addr,
   input wire logic [7:0] reg_wr_data,
   input wire logic [7:0] reg_rd_addr,
   output logic [7:0] reg_rd_data_r,
   input wire logic low_power_mode,
   input wire logic [7:0] conv_data,
   output logic conv_active_r,
   output logic [2:0] conv_channel_r,
   output logic range_high_r,
   output logic [3:0] result_step_mv_r,
   output logic set_done_r,
   input wire logic [2:0] result_rd_idx,
   output logic [7:0] result_rd_data_r
);
   initial begin
      if (CHAN_CYCLES < 2) $error("mac_ctrl: CHAN_CYCLES too small");
      if (PERIOD_CYCLES < CHAN_CYCLES * MAC_NUM_CHAN + 4) $error("mac_ctrl: PERIOD too short");
   end

   // ************************************************************
   // Helpers
   // ************************************************************
   // Lowest enabled channel at or above from; 8 means none left
   function automatic logic [3:0] next_en(input logic [7:0] m, input logic [3:0] from);
      logic [3:0] r;
      r = 4'h8;
      for (int i = MAC_NUM_CHAN - 1; i >= 0; i--) begin
         if (m[i] && (4'(i) >= from)) r = 4'(i);
      end
      return r;
   endfunction

   function automatic logic [3:0] step_mv(input logic hi);
      return hi ? MAC_STEP_HIGH_MV : MAC_STEP_LOW_MV;
   endfunction

   // ************************************************************
   // Option register
   // ************************************************************
   logic [15:0] opt_r;
   logic done_evt;
   logic wr_lo, wr_hi;
   mac_state_type state_r, state_nxt;
   logic [7:0] mask_r;
   logic [31:0] slot_cnt_r, period_cnt_r;
   logic [2:0] chan_nxt;
   logic [3:0] first_ch, follow_ch;
   logic slot_end;

   assign wr_lo = reg_wr_en && (reg_wr_addr == MAC_ADDR_OPT_LO);
   assign wr_hi = reg_wr_en && (reg_wr_addr == MAC_ADDR_OPT_HI);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         opt_r <= MAC_OPT_RESET; // [RULE8] [RULE10]
      end else begin
         if (wr_lo) begin
            opt_r[7:0] <= reg_wr_data; // [RULE10]
         end
         if (wr_hi) begin
            opt_r[15:8] <= reg_wr_data; // [RULE3] [RULE11]
         end else if (done_evt && !opt_r[MAC_BIT_MODE]) begin
            // A host write in the same cycle wins over the self clear
            opt_r[MAC_BIT_START] <= 1'b0; // [RULE3]
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rd_data_r <= 8'h00;
      end else begin
         unique case (reg_rd_addr)
            MAC_ADDR_OPT_LO: reg_rd_data_r <= opt_r[7:0];
            MAC_ADDR_OPT_HI: reg_rd_data_r <= opt_r[15:8];
            default: reg_rd_data_r <= 8'h00;
         endcase
      end
   end

   // ************************************************************
   // Sequencer
   // ************************************************************
   assign first_ch = next_en(opt_r[7:0], 4'h0); // [RULE5]
   assign follow_ch = next_en(mask_r, {1'b0, conv_channel_r} + 4'h1); // [RULE5]
   assign slot_end = (state_r == MAC_ST_CONV) && (slot_cnt_r == 32'(CHAN_CYCLES - 1)); // [RULE4]

   always_comb begin
      state_nxt = state_r;
      chan_nxt = conv_channel_r;
      done_evt = 1'b0;
      unique case (state_r)
         MAC_ST_IDLE: begin
            if (opt_r[MAC_BIT_START] && !low_power_mode) begin // [RULE1] [RULE6]
               if (first_ch[3]) begin
                  done_evt = 1'b1;
                  // An empty continuous set still waits out its period
                  state_nxt = opt_r[MAC_BIT_MODE] ? MAC_ST_WAIT : MAC_ST_IDLE; // [RULE2]
               end else begin
                  state_nxt = MAC_ST_CONV;
                  chan_nxt = first_ch[2:0];
               end
            end
         end
         MAC_ST_CONV: begin
            if (low_power_mode) begin
               state_nxt = MAC_ST_IDLE; // [RULE6]
            end else if (slot_end) begin
               if (follow_ch[3]) begin
                  done_evt = 1'b1;
                  // Continuous sets pause until the period expires
                  state_nxt = (opt_r[MAC_BIT_MODE] && opt_r[MAC_BIT_START])
                     ? MAC_ST_WAIT : MAC_ST_IDLE; // [RULE2] [RULE11]
               end else begin
                  chan_nxt = follow_ch[2:0];
               end
            end
         end
         MAC_ST_WAIT: begin
            if (low_power_mode || !opt_r[MAC_BIT_START]) begin
               state_nxt = MAC_ST_IDLE; // [RULE6] [RULE11]
            end else if (period_cnt_r >= 32'(PERIOD_CYCLES - 2)) begin
               state_nxt = MAC_ST_IDLE; // [RULE2]
            end
         end
         default: state_nxt = MAC_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= MAC_ST_IDLE;
         conv_active_r <= 1'b0;
         conv_channel_r <= MAC_CH_BATTERY_VOLTAGE;
         set_done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         conv_active_r <= (state_nxt == MAC_ST_CONV); // [RULE6]
         conv_channel_r <= chan_nxt;
         set_done_r <= done_evt; // [RULE1] [RULE2]
      end
   end

   // Enables are frozen for the set so a mid-set write cannot reorder it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mask_r <= 8'h00;
      end else if (state_r == MAC_ST_IDLE) begin
         mask_r <= opt_r[7:0];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         slot_cnt_r <= 32'h0;
      end else if (state_r != MAC_ST_CONV || slot_end) begin
         slot_cnt_r <= 32'h0;
      end else begin
         slot_cnt_r <= slot_cnt_r + 32'h1; // [RULE4]
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         period_cnt_r <= 32'h0;
      end else if (state_r == MAC_ST_IDLE) begin
         period_cnt_r <= 32'h0;
      end else begin
         period_cnt_r <= period_cnt_r + 32'h1; // [RULE2]
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         range_high_r <= 1'b1;
         result_step_mv_r <= MAC_STEP_HIGH_MV;
      end else begin
         range_high_r <= opt_r[MAC_BIT_RANGE]; // [RULE8]
         result_step_mv_r <= step_mv(opt_r[MAC_BIT_RANGE]); // [RULE9]
      end
   end

   // ************************************************************
   // Results
   // ************************************************************
   mac_result_mem #(.WIDTH(8), .DEPTH(MAC_NUM_CHAN)) u_mem (
      .clk(clk),
      .wr_en(slot_end && !low_power_mode), // [RULE1] [RULE2]
      .wr_idx(conv_channel_r),
      .wr_data(conv_data),
      .rd_idx(result_rd_idx),
      .rd_data_r(result_rd_data_r)
   );

   // ************************************************************
   // Assertions
   // ************************************************************
   sequence s_oneshot_done;
      done_evt && !opt_r[MAC_BIT_MODE] && !wr_hi;
   endsequence

   sequence s_start_low;
      !opt_r[MAC_BIT_START] && !conv_active_r;
   endsequence

   a_start_self_clear: assert property (@(posedge clk) disable iff (!reset_n) // [RULE3]
      s_oneshot_done |=> s_start_low)
      else $error("start not cleared after one-shot set");

   a_start_write_one: assert property (@(posedge clk) disable iff (!reset_n) // [RULE3]
      wr_hi && reg_wr_data[MAC_BIT_START-8] |=> opt_r[MAC_BIT_START])
      else $error("start write lost");

   a_lowpower_inactive: assert property (@(posedge clk) disable iff (!reset_n) // [RULE6]
      low_power_mode |=> !conv_active_r)
      else $error("converter active in low power mode");

   a_slot_bound: assert property (@(posedge clk) disable iff (!reset_n) // [RULE4]
      slot_cnt_r < 32'(CHAN_CYCLES))
      else $error("slot longer than channel time");

   a_slot_hold: assert property (@(posedge clk) disable iff (!reset_n) // [RULE4]
      conv_active_r && !slot_end && !low_power_mode |=> conv_channel_r == $past(conv_channel_r))
      else $error("channel changed inside a slot");

   a_channel_order: assert property (@(posedge clk) disable iff (!reset_n) // [RULE5]
      slot_end && !follow_ch[3] && !low_power_mode
         |=> conv_active_r && conv_channel_r > $past(conv_channel_r))
      else $error("channel order broken");

   a_channel_enabled: assert property (@(posedge clk) disable iff (!reset_n) // [RULE10]
      conv_active_r |-> mask_r[conv_channel_r])
      else $error("disabled channel converted");

   a_period_bound: assert property (@(posedge clk) disable iff (!reset_n) // [RULE2]
      period_cnt_r < 32'(PERIOD_CYCLES))
      else $error("continuous period overrun");

   a_stop_further: assert property (@(posedge clk) disable iff (!reset_n) // [RULE11]
      state_r == MAC_ST_WAIT && !opt_r[MAC_BIT_START] |=> state_r == MAC_ST_IDLE)
      else $error("continuous sets not stopped");

   a_range_step: assert property (@(posedge clk) disable iff (!reset_n) // [RULE8] [RULE9]
      ##1 result_step_mv_r == (range_high_r ? 4'hC : 4'h8))
      else $error("step does not match range");
endmodule
`default_nettype wire

// *** test/mac_conv_model.sv ***
// Purpose: Converter stand-in that feeds a code for the channel in its slot
// Assumes: A code is only meaningful while a slot runs
// Notes: Outside slots the code is inverted, so stale data never passes
`timescale 1ns/10ps
`default_nettype none
module mac_conv_model (
   input wire logic conv_active,
   input wire logic [2:0] channel,
   input wire logic [4:0] salt,
   output logic [7:0] conv_data
);
   // ****************
   // Code source
   // ****************
   assign conv_data = conv_active ? {channel, salt} : ~{channel, salt};
endmodule
`default_nettype wire

// *** test/mac_ctrl_tb.sv ***
// Purpose: Self-checking bench for the monitor converter control
// Assumes: Short slot and period counts
// Notes: Queue model of channel order, slot counts and stored codes
`timescale 1ns/10ps
`default_nettype none
module mac_ctrl_tb;
   import mac_pkg::*;
   localparam int CH = 10;
   localparam int PER = 100;
   logic clk = 1'b0, reset_n = 1'b0, reg_wr_en = 1'b0, low_power_mode = 1'b0;
   logic [7:0] reg_wr_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_addr = 8'h00;
   logic [7:0] reg_rd_data_r, conv_data, result_rd_data_r;
   logic conv_active_r, range_high_r, set_done_r;
   logic [2:0] conv_channel_r, result_rd_idx = 3'h0;
   logic [3:0] result_step_mv_r;
   logic [4:0] salt = 5'h00;
   logic [7:0] ens[5] = '{8'h00, 8'h80, 8'hFF, 8'h00, 8'h00};
   int mismatches = 0, checks = 0, seed = 19452, act_cnt = 0, dones = 0, cyc = 0;
   int t1, d;
   logic [2:0] chq[$];
   always #2.5 clk = ~clk;
   mac_ctrl #(.CHAN_CYCLES(CH), .PERIOD_CYCLES(PER)) dut (.clk(clk), .reset_n(reset_n),
      .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
      .reg_rd_addr(reg_rd_addr), .reg_rd_data_r(reg_rd_data_r), .low_power_mode(low_power_mode),
      .conv_data(conv_data), .conv_active_r(conv_active_r), .conv_channel_r(conv_channel_r),
      .range_high_r(range_high_r), .result_step_mv_r(result_step_mv_r),
      .set_done_r(set_done_r), .result_rd_idx(result_rd_idx), .result_rd_data_r(result_rd_data_r));
   mac_conv_model partner (.conv_active(conv_active_r), .channel(conv_channel_r), .salt(salt),
      .conv_data(conv_data));
   // ****************
   // Monitor
   // ****************
   always @(posedge clk) begin
      cyc++;
      if (conv_active_r === 1'b1) begin
         act_cnt++;
         if (chq.size() == 0 || chq[$] !== conv_channel_r) chq.push_back(conv_channel_r);
      end
      if (set_done_r === 1'b1) begin
         dones++;
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      #1 reg_wr_en = 1'b1;
      reg_wr_addr = a;
      reg_wr_data = v;
      @(posedge clk);
      #1 reg_wr_en = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      #1 reg_rd_addr = a;
      repeat (2) @(posedge clk);
      #1 chk(reg_rd_data_r, exp);
   endtask
   // Bounded wait so a stuck sequencer shows as a mismatch, not a hang
   task automatic wait_done(input int lim);
      int n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (set_done_r !== 1'b1 && n < lim);
      if (n >= lim) chk({7'h0, set_done_r}, 8'h01);
   endtask
   task automatic one_shot(input logic [7:0] en);
      logic [2:0] exq[$];
      salt = 5'($random(seed));
      for (int c = 0; c < 8; c++) if (en[c]) exq.push_back(3'(c));
      wr(MAC_ADDR_OPT_LO, en);
      chq.delete();
      act_cnt = 0;
      wr(MAC_ADDR_OPT_HI, 8'h40);
      wait_done(8 * CH + 20);
      chk(8'(chq.size()), 8'(exq.size()));
      for (int i = 0; i < exq.size(); i++) chk({5'h0, chq[i]}, {5'h0, exq[i]});
      chk(8'(act_cnt), 8'(CH * exq.size()));
      rd(MAC_ADDR_OPT_HI, 8'h00);
      foreach (exq[i]) begin
         result_rd_idx = exq[i];
         repeat (2) @(posedge clk);
         #1 chk(result_rd_data_r, {exq[i], salt});
      end
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #50000;
      mismatches++;
      tally_and_finish;
   end
   initial begin
      repeat (8) @(posedge clk);
      #1 reset_n = 1'b1;
      rd(MAC_ADDR_OPT_LO, 8'h00);
      rd(MAC_ADDR_OPT_HI, 8'h20);
      chk({7'h0, range_high_r}, 8'h01);
      chk({4'h0, result_step_mv_r}, 8'h0C);
      rd(8'h3C, 8'h00);
      ens[3] = 8'($random(seed));
      ens[4] = 8'($random(seed));
      foreach (ens[i]) one_shot(ens[i]);
      wr(MAC_ADDR_OPT_HI, 8'h20);
      rd(MAC_ADDR_OPT_HI, 8'h20);
      chk({4'h0, result_step_mv_r}, 8'h0C);
      wr(MAC_ADDR_OPT_HI, 8'h00);
      rd(MAC_ADDR_OPT_HI, 8'h00);
      chk({7'h0, range_high_r}, 8'h00);
      chk({4'h0, result_step_mv_r}, 8'h08);
      wr(MAC_ADDR_OPT_LO, 8'h03);
      wr(MAC_ADDR_OPT_HI, 8'hC0);
      wait_done(PER + 40);
      // Both waits return at the same phase after the pulse, so cycle counts compare directly
      t1 = cyc;
      wait_done(PER + 20);
      chk(8'(cyc - t1), 8'(PER));
      rd(MAC_ADDR_OPT_HI, 8'hC0);
      wait_done(PER + 20);
      wr(MAC_ADDR_OPT_HI, 8'h80);
      d = dones;
      repeat (3 * PER) @(posedge clk);
      #1 chk(8'(dones - d), 8'h00);
      wr(MAC_ADDR_OPT_LO, 8'hFF);
      wr(MAC_ADDR_OPT_HI, 8'h40);
      repeat (15) @(posedge clk);
      #1 low_power_mode = 1'b1;
      repeat (3) @(posedge clk);
      #1 d = act_cnt;
      t1 = dones;
      repeat (50) @(posedge clk);
      #1 chk(8'(act_cnt - d), 8'h00);
      chk({7'h0, conv_active_r}, 8'h00);
      chk(8'(dones - t1), 8'h00);
      low_power_mode = 1'b0;
      wait_done(8 * CH + 20);
      rd(MAC_ADDR_OPT_HI, 8'h00);
      tally_and_finish;
   end
endmodule
`default_nettype wire
